// file: serial_host_model.sv
`default_nettype none

module serial_host_model (
  input wire logic clock,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  output logic serial_clock,
  output logic chip_select_n,
  output logic sdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic bit_v = 1'b0;
  logic rel = 1'b0;
  logic lsb = 1'b0;
  logic unidir = 1'b0;
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
  end
  // Released lines toggle
  always @(posedge clock) rel <= ~rel;
  assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_v : rel);
  task automatic step(input logic b, output logic r);
    @(posedge clock);
    #1;
    serial_clock = 1'b0;
    bit_v = b;
    repeat (4) @(posedge clock);
    #1;
    serial_clock = 1'b1;
    r = unidir ? (serial_data_out_oe ? serial_data_out : rel) : sdio_in;
    repeat (3) @(posedge clock);
  endtask
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] ins;
    logic r;
    int i;
    ins = {rd, 2'b00, a};
    rdat = 8'h00;
    @(posedge clock);
    #1;
    chip_select_n = 1'b0;
    drv = 1'b1;
    for (i = 0; i < 16; i++) step(lsb ? ins[i] : ins[15-i], r);
    drv = !rd;
    for (i = 0; i < 8; i++) begin
      step(lsb ? wd[i] : wd[7-i], r);
      rdat[lsb ? i : 7-i] = r;
    end
    repeat (2) @(posedge clock);
    #1;
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    drv = 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// file: serial_port_config_and_system_regs.sv
`default_nettype none

module serial_port_config_and_system_regs
  #(
  parameter logic [7:0] VARIANT_ID = 8'h5a  // Arbitrary value
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic soft_sync,
  output logic power_down_distribution_ref,
  output logic power_down_sync
);

  import serial_port_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    frame_state_t state;
    logic sclk_prev;
    logic [3:0] bit_cnt;
    logic [15:0] instr_shift;
    logic [7:0] data_shift;
    logic [12:0] addr;
    logic [1:0] bytes_left;
    logic streaming;
    logic load_pending;
    logic soft_reset;
    logic lsb_first;
    logic unidirectional_select;
    logic readback_active;
    logic sdio_out;
    logic sdio_oe;
    logic serial_data_out;
    logic serial_data_out_oe;
  } port_state_t;

  port_state_t r_reg;
  port_state_t r_next;

  // ----------------------------------------------------------------
  // Reset state
  // ----------------------------------------------------------------
  localparam port_state_t RESET_STATE = '{
    state: ST_INSTR,
    sclk_prev: 1'b0,
    bit_cnt: 4'h0,
    instr_shift: 16'h0000,
    data_shift: 8'h00,
    addr: 13'h0000,
    bytes_left: 2'b00,
    streaming: 1'b0,
    load_pending: 1'b0,
    soft_reset: CFG_RESET[CFG_SOFT_RESET_BIT],
    lsb_first: CFG_RESET[CFG_LSB_FIRST_BIT],
    unidirectional_select: CFG_RESET[CFG_UNIDIR_BIT],
    readback_active: READBACK_RESET,
    sdio_out: 1'b0,
    sdio_oe: 1'b0,
    serial_data_out: 1'b0,
    serial_data_out_oe: 1'b0
  };

  logic rise;
  logic fall;
  logic [15:0] word;
  logic [7:0] data_byte;
  logic ps_write;
  logic [PS_WIDTH-1:0] ps_data;
  logic update_all;
  logic [PS_WIDTH-1:0] ps_buffered;
  logic [PS_WIDTH-1:0] ps_active;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) begin
      o[i] = v[7-i];
    end
    return o;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    return {rev8(v[7:0]), rev8(v[15:8])};
  endfunction

  function automatic logic [3:0] bump(input logic [3:0] cnt);
    return cnt + 4'h1;
  endfunction

  // Upper nibble is the reversed lower nibble
  function automatic logic [7:0] mirror_config(input logic [3:0] low);
    return {low[0], low[1], low[2], low[3], low};
  endfunction

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------

  function automatic logic [7:0] read_byte(input port_state_t s, input logic [PS_WIDTH-1:0] buf_q,
                                           input logic [PS_WIDTH-1:0] act_q);
    logic [3:0] low;
    logic [7:0] o;
    low = {1'b1, s.soft_reset, s.lsb_first, s.unidirectional_select};
    o = 8'h00;
    case (s.addr)
      ADDR_SERIAL_CONFIG: o = mirror_config(low);
      ADDR_VARIANT_IDENTIFIER: o = VARIANT_ID;
      ADDR_READBACK_BANK_SELECT: o = {7'h00, s.readback_active};
      ADDR_POWER_DOWN_AND_SYNC: o = {5'h00, s.readback_active ? act_q : buf_q};
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  // Address step and byte accounting after each data byte
  function automatic port_state_t end_of_byte(input port_state_t s, input port_state_t n_in);
    port_state_t n;
    n = n_in;
    n.bit_cnt = 4'h0;
    n.addr = s.lsb_first ? s.addr + 13'h0001 : s.addr - 13'h0001;
    if (!s.streaming && s.bytes_left == 2'b00) begin
      n.state = ST_DONE;
    end else if (!s.streaming) begin
      n.bytes_left = s.bytes_left - 2'b01;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Serial clock edges
  // ----------------------------------------------------------------
  assign rise = serial_clock & ~r_reg.sclk_prev;
  assign fall = ~serial_clock & r_reg.sclk_prev;

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    word = 16'h0000;
    data_byte = 8'h00;
    ps_write = 1'b0;
    ps_data = '0;
    update_all = 1'b0;
    r_next.sclk_prev = serial_clock;
    if (r_reg.soft_reset) begin
      r_next.lsb_first = CFG_RESET[CFG_LSB_FIRST_BIT];
      r_next.unidirectional_select = CFG_RESET[CFG_UNIDIR_BIT];
      r_next.readback_active = READBACK_RESET;
    end
    if (chip_select_n) begin
      r_next.state = ST_INSTR;
      r_next.bit_cnt = 4'h0;
      r_next.load_pending = 1'b0;
      r_next.sdio_oe = 1'b0;
      r_next.serial_data_out_oe = 1'b0;
    end else begin
      case (r_reg.state)
        ST_INSTR: begin
          if (rise) begin
            word = {r_reg.instr_shift[14:0], sdio_in};
            r_next.instr_shift = word;
            r_next.bit_cnt = bump(r_reg.bit_cnt);
            if (r_reg.bit_cnt == INSTR_LAST_BIT) begin
              if (r_reg.lsb_first) begin
                word = rev16(word);
              end
              r_next.addr = word[ADDR_BITS-1:0];
              r_next.bytes_left = word[INSTR_LEN_HI_BIT:INSTR_LEN_LO_BIT];
              r_next.streaming = &word[INSTR_LEN_HI_BIT:INSTR_LEN_LO_BIT];
              r_next.bit_cnt = 4'h0;
              r_next.load_pending = word[INSTR_READ_BIT];
              r_next.state = word[INSTR_READ_BIT] ? ST_READ : ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (rise) begin
            data_byte = {r_reg.data_shift[6:0], sdio_in};
            r_next.data_shift = data_byte;
            r_next.bit_cnt = bump(r_reg.bit_cnt);
            if (r_reg.bit_cnt == BYTE_LAST_BIT) begin
              if (r_reg.lsb_first) begin
                data_byte = rev8(data_byte);
              end
              case (r_reg.addr)
                ADDR_SERIAL_CONFIG: begin
                  r_next.soft_reset = data_byte[CFG_SOFT_RESET_BIT];
                  r_next.lsb_first = data_byte[CFG_LSB_FIRST_BIT];
                  r_next.unidirectional_select = data_byte[CFG_UNIDIR_BIT];
                end
                ADDR_READBACK_BANK_SELECT: r_next.readback_active = data_byte[READBACK_ACTIVE_BIT];
                ADDR_POWER_DOWN_AND_SYNC: begin
                  ps_write = 1'b1;
                  ps_data = data_byte[PS_WIDTH-1:0];
                end
                ADDR_UPDATE_STROBE: update_all = data_byte[UPDATE_BIT];
                default: ;
              endcase
              r_next = end_of_byte(r_reg, r_next);
            end
          end
        end
        ST_READ: begin
          if (fall) begin
            if (r_reg.load_pending) begin
              data_byte = read_byte(r_reg, ps_buffered, ps_active);
              if (r_reg.lsb_first) begin
                data_byte = rev8(data_byte);
              end
              r_next.load_pending = 1'b0;
            end else begin
              data_byte = r_reg.data_shift;
            end
            r_next.sdio_out = data_byte[7];
            r_next.serial_data_out = data_byte[7];
            r_next.data_shift = {data_byte[6:0], 1'b0};
            r_next.sdio_oe = ~r_reg.unidirectional_select;
            r_next.serial_data_out_oe = r_reg.unidirectional_select;
          end
          if (rise) begin
            r_next.bit_cnt = bump(r_reg.bit_cnt);
            if (r_reg.bit_cnt == BYTE_LAST_BIT) begin
              r_next = end_of_byte(r_reg, r_next);
              r_next.load_pending = 1'b1;
            end
          end
        end
        ST_DONE: begin
          r_next.sdio_oe = 1'b0;
          r_next.serial_data_out_oe = 1'b0;
        end
        default: r_next.state = ST_INSTR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      r_reg <= RESET_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Power-down and sync register, buffered and active
  // ----------------------------------------------------------------
  // buffered and active banks
  staged_register #(
    .WIDTH(PS_WIDTH),
    .RESET_VALUE(PS_RESET)
  ) u_power_sync (
    .clock(clock),
    .resetn(resetn),
    .soft_reset(r_reg.soft_reset),
    .write_en(ps_write),
    .write_data(ps_data),
    .update(update_all),
    .buffered_q(ps_buffered),
    .active_q(ps_active)
  );

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  assign sdio_out = r_reg.sdio_out;
  assign sdio_oe = r_reg.sdio_oe;
  assign serial_data_out = r_reg.serial_data_out;
  assign serial_data_out_oe = r_reg.serial_data_out_oe;
  assign soft_sync = ps_active[PS_SOFT_SYNC_BIT];
  assign power_down_distribution_ref = ps_active[PS_PD_DIST_REF_BIT];
  assign power_down_sync = ps_active[PS_PD_SYNC_BIT];

endmodule

`default_nettype wire

// file: serial_port_config_and_system_regs_assertions.sv
`default_nettype none

module spc_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_data_out_oe,
  input wire logic soft_sync,
  input wire logic power_down_distribution_ref,
  input wire logic power_down_sync
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic [2:0] ps;
  assign ps = {power_down_sync, power_down_distribution_ref, soft_sync};
  sequence idle3;
    chip_select_n [*3];
  endsequence
  sequence oe_off;
    !sdio_oe && !serial_data_out_oe;
  endsequence
  a_oe_exclusive: assert property (!(sdio_oe && serial_data_out_oe))
    else $error("both data enables high");
  a_reset_clears: assert property ($rose(resetn) |-> oe_off and ps == 3'h0)
    else $error("outputs not cleared by reset");
  a_oe_release_bound: assert property ($rose(chip_select_n) |-> ##[1:2] oe_off)
    else $error("enable held after frame end");
  a_oe_needs_frame: assert property (sdio_oe |-> !$past(chip_select_n, 2))
    else $error("data pin driven outside frame");
  a_data_moves_low: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out) |->
    !serial_clock && !$past(serial_clock))
    else $error("read bit changed off the falling phase");
  a_unidir_rise_low: assert property ($rose(serial_data_out_oe) |-> !serial_clock && !$past(serial_clock))
    else $error("output pin enabled off the falling phase");
  a_pins_in_frame: assert property ($changed(ps) |-> !$past(chip_select_n))
    else $error("active bits changed outside a frame");
  a_idle_stable: assert property (idle3 |=> $stable(ps) and oe_off)
    else $error("idle port not quiet");
endmodule

bind serial_port_config_and_system_regs spc_checker chk (.clock(clock), .resetn(resetn),
  .serial_clock(serial_clock), .chip_select_n(chip_select_n), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .serial_data_out_oe(serial_data_out_oe), .soft_sync(soft_sync),
  .power_down_distribution_ref(power_down_distribution_ref), .power_down_sync(power_down_sync));

`default_nettype wire

// file: serial_port_pkg.sv
`default_nettype none

package serial_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_BITS = 13;
  localparam logic [12:0] ADDR_SERIAL_CONFIG = 13'h000;
  localparam logic [12:0] ADDR_VARIANT_IDENTIFIER = 13'h003;
  localparam logic [12:0] ADDR_READBACK_BANK_SELECT = 13'h004;
  localparam logic [12:0] ADDR_POWER_DOWN_AND_SYNC = 13'h230;
  localparam logic [12:0] ADDR_SYSTEM_RESERVED = 13'h231;
  localparam logic [12:0] ADDR_UPDATE_STROBE = 13'h232;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_UNIDIR_BIT = 0;
  localparam int CFG_LSB_FIRST_BIT = 1;
  localparam int CFG_SOFT_RESET_BIT = 2;
  localparam int CFG_LONG_INSTR_BIT = 3;
  localparam int READBACK_ACTIVE_BIT = 0;
  localparam int PS_SOFT_SYNC_BIT = 0;
  localparam int PS_PD_DIST_REF_BIT = 1;
  localparam int PS_PD_SYNC_BIT = 2;
  localparam int PS_WIDTH = 3;
  localparam int UPDATE_BIT = 0;
  localparam int INSTR_READ_BIT = 15;
  localparam int INSTR_LEN_HI_BIT = 14;
  localparam int INSTR_LEN_LO_BIT = 13;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h18;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic READBACK_RESET = 1'b0;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10,
    ST_DONE = 2'b11
  } frame_state_t;

endpackage

`default_nettype wire

// file: staged_register.sv
`default_nettype none

module staged_register #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic write_en,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic update,
  output logic [WIDTH-1:0] buffered_q,
  output logic [WIDTH-1:0] active_q
);

  typedef struct packed {
    logic [WIDTH-1:0] buffered;
    logic [WIDTH-1:0] active;
  } staged_t;

  staged_t r_reg;
  staged_t r_next;

  if (WIDTH < 1) begin : g_width_check
    $error("staged_register width must be at least one");
  end

  always_comb begin
    r_next = r_reg;
    if (write_en) begin
      r_next.buffered = write_data;
    end
    if (update) begin
      r_next.active = r_reg.buffered;
    end
    if (soft_reset) begin
      r_next.buffered = RESET_VALUE;
      r_next.active = RESET_VALUE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r_reg <= '{buffered: RESET_VALUE, active: RESET_VALUE};
    end else begin
      r_reg <= r_next;
    end
  end

  assign buffered_q = r_reg.buffered;
  assign active_q = r_reg.active;

endmodule

`default_nettype wire

// file: tb_serial_port_config_and_system_regs.sv
`default_nettype none

module tb_serial_port_config_and_system_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VID = 8'h5a; // Arbitrary value
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic serial_clock, chip_select_n, sdio_in, sdio_out, sdio_oe, serial_data_out, serial_data_out_oe;
  logic soft_sync, power_down_distribution_ref, power_down_sync;
  logic [7:0] m_cfg = 8'h18, m_rb = 8'h00, m_buf = 8'h00, m_act = 8'h00, v;
  logic [7:0] modes [4] = '{8'h5a, 8'hdb, 8'h99, 8'h18};
  int error_cnt = 0, tests_run = 0, cycles = 0, k;
  always #2 clock = ~clock;
  serial_port_config_and_system_regs #(.VARIANT_ID(VID)) dut (.clock(clock), .resetn(resetn),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .soft_sync(soft_sync), .power_down_distribution_ref(power_down_distribution_ref),
    .power_down_sync(power_down_sync));
  serial_host_model host (.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .sdio_in(sdio_in));
  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pins();
    tests_run++;
    if ({power_down_sync, power_down_distribution_ref, soft_sync} !== m_act[2:0]) begin
      error_cnt++;
      $display("MISMATCH t=%0t pins expected %h", $time, m_act[2:0]);
    end
  endtask
  function automatic logic [7:0] expect_rd(input logic [12:0] a);
    case (a)
      13'h000: return m_cfg;
      13'h003: return VID;
      13'h004: return m_rb;
      13'h230: return m_rb[0] ? m_act : m_buf;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame(1'b0, a, d, r);
    case (a)
      13'h000: m_cfg = d[2] ? 8'h3c : {d[0], d[1], 1'b0, 1'b1, 1'b1, 1'b0, d[1:0]};
      13'h004: m_rb = {7'h00, d[0]};
      13'h230: m_buf = {5'h00, d[2:0]};
      13'h232: m_act = d[0] ? m_buf : m_act;
      default: ;
    endcase
    if (a == 13'h000 && d[2]) begin
      m_rb = 8'h00;
      m_buf = 8'h00;
      m_act = 8'h00;
    end
    host.lsb = m_cfg[1];
    host.unidir = m_cfg[0];
  endtask
  task automatic rd(input logic [12:0] a);
    logic [7:0] r;
    host.frame(1'b1, a, 8'h00, r);
    check_read(r, expect_rd(a));
  endtask
  initial begin
    void'($urandom(32'h1d09));
    repeat (12) @(posedge clock);
    #1;
    resetn = 1'b1;
    check_pins();
    rd(13'h000);
    rd(13'h004);
    rd(13'h230);
    wr(13'h003, 8'ha5);
    rd(13'h003);
    rd(13'h231);
    rd(13'h100);
    for (k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(13'h230, v);
      check_pins();
      rd(13'h230);
      wr(13'h004, 8'h01);
      rd(13'h230);
      wr(13'h232, 8'h01);
      check_pins();
      rd(13'h232);
      wr(13'h004, 8'h00);
      wr(13'h000, modes[k]);
      rd(13'h000);
    end
    wr(13'h230, 8'h07);
    wr(13'h232, 8'h01);
    wr(13'h004, 8'h01);
    wr(13'h000, 8'h3c);
    check_pins();
    rd(13'h000);
    rd(13'h004);
    rd(13'h230);
    wr(13'h000, 8'h18);
    rd(13'h000);
    complete_run();
  end
endmodule

`default_nettype wire
